// >>> core/spi_status_readback.sv
/*
 * Serial status return path of a quad switch slave port: builds the
 * 16-bit return word, shifts it out, echoes received bits, checks frame
 * length and hands committed words to the register bank.
 * Assumes the serial clock idles low, the master samples the return bit
 * on the rising serial edge, and the link runs far slower than the core.
 */
// Summary of operation
// [RULE1] Return word loads into the shift register when select falls.
// [RULE2] Data leaves top bit first while command bits shift in.
// [RULE3] First sixteen bits out depend on the previous command.
// [RULE4] After sixteen bits, received bits are echoed out for chaining.
// [RULE5] On select rise, only whole multiples of 16 bits are committed.
// [RULE6] Select rise tri-states output; valid frame re-enables capture.
// [RULE7] A select command's five-bit code chooses returned content.
// [RULE8] Top two code bits pick the output for per-output items.
// [RULE9] Chosen item persists until a new select command.
// [RULE10] Return word shows selected data as it stood at select fall.
// [RULE11] An invalid-length frame changes nothing that is reported; bit 8 power-on flag still clears if fault readback was selected.
// [RULE12] Top return bit carries the previous watchdog toggle bit.
// [RULE13] Bits 14..10 repeat the readback code from the last select command.
// [RULE14] Bit 9 is one while in normal run mode.
// [RULE15] Bits 8..0 carry content chosen by the readback code.
// [RULE16] Code map: per-output 0..4, globals 05, 07, 0F, 17.
// [RULE17] After reset all returned fields read zero; bit 8 aside.
// [RULE18] Fault readback: bit 8 power-on flag, cleared by reading.
// [RULE19] Register codes return programmed contents of that output.
// [RULE20] Diag word zero: clock range, calibration fail, heat warning.
// [RULE21] Diag word one: direct inputs in bits 4..1, watchdog in 0.
module spi_status_readback #(
    parameter logic [8:0] IDENT_BITS = 9'h004 // arbitrary except bit 2
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Serial pins
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        si_i,
    output logic             so_o,
    output logic             so_oe_n_o,
    // Direct input pins
    input  wire logic [3:0]  direct_input_i,
    // Device state, core clock domain
    input  wire logic        normal_run_flag_i,
    input  wire logic        power_on_event_i,
    input  wire logic [31:0] fault_latch_i,
    input  wire logic [31:0] duty_register_i,
    input  wire logic [23:0] output_config_a_i,
    input  wire logic [27:0] output_fault_config_i,
    input  wire logic [31:0] current_limit_config_i,
    input  wire logic [8:0]  global_config_i,
    input  wire logic [2:0]  diag_word_zero_i,
    input  wire logic        watchdog_active_flag_i,
    // Commit to register bank
    output logic             write_strobe_o,
    output logic [4:0]       write_addr_o,
    output logic [8:0]       write_data_o,
    output logic             watchdog_toggle_bit_o,
    output logic             fault_capture_en_o,
    output logic [4:0]       readback_code_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling
    logic [spi_readback_pkg::PIN_W-1:0] pins_s;
    logic        sclk_s;
    logic        cs_n_s;
    logic        si_s;
    logic [3:0]  din_s;
    logic        sclk_prev_reg;
    logic        cs_n_prev_reg;
    logic        cs_fall;
    logic        cs_rise;
    logic        sclk_rise;
    logic        sclk_fall;

    pin_sync #(
        .W       (spi_readback_pkg::PIN_W),
        .RST_VAL (spi_readback_pkg::PIN_RESET)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    ({sclk_i, cs_n_i, si_i, direct_input_i}),
        .sync_o     (pins_s)
    );

    assign sclk_s = pins_s[6];
    assign cs_n_s = pins_s[5];
    assign si_s   = pins_s[4];
    assign din_s  = pins_s[3:0];

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            sclk_prev_reg <= 1'h0;
            cs_n_prev_reg <= 1'h1;
        end
        else
        begin
            sclk_prev_reg <= sclk_s;
            cs_n_prev_reg <= cs_n_s;
        end
    end

    assign cs_fall   = cs_n_prev_reg & ~cs_n_s;
    assign cs_rise   = ~cs_n_prev_reg & cs_n_s;
    assign sclk_rise = ~cs_n_s & ~sclk_prev_reg & sclk_s;
    assign sclk_fall = ~cs_n_s & sclk_prev_reg & ~sclk_s;

    ////////////////////////////////////////////////////////////////////////
    // Frame state and commit
    logic [15:0] shift_reg;
    logic [3:0]  count_reg;
    logic        any_bits_reg;
    logic        frame_valid;
    logic [4:0]  sel_code_reg;
    logic        por_flag_reg;
    logic [4:0]  rx_addr;

    assign frame_valid = any_bits_reg && (count_reg == 4'h0); // [RULE5]
    assign rx_addr     = shift_reg[spi_readback_pkg::ADDR_HI:
                                   spi_readback_pkg::ADDR_LO];

    // Count wraps every 16 bits; the flag catches an empty frame
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            count_reg    <= 4'h0;
            any_bits_reg <= 1'h0;
        end
        else if (cs_fall)
        begin
            count_reg    <= 4'h0;
            any_bits_reg <= 1'h0;
        end
        else if (sclk_rise)
        begin
            count_reg    <= count_reg + 4'h1;
            any_bits_reg <= 1'h1;
        end
    end

    // Last whole word of a valid frame is the command; others are dropped
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            write_strobe_o        <= 1'h0;
            write_addr_o          <= 5'h00;
            write_data_o          <= 9'h000;
            watchdog_toggle_bit_o <= 1'h0;
            sel_code_reg          <= spi_readback_pkg::CODE_RESET;
        end
        else
        begin
            write_strobe_o <= cs_rise && frame_valid; // [RULE5] [RULE11]
            if (cs_rise && frame_valid)
            begin
                write_addr_o          <= rx_addr;
                write_data_o          <= shift_reg[8:0];
                watchdog_toggle_bit_o <=
                    shift_reg[spi_readback_pkg::WD_BIT]; // [RULE12]
                if (rx_addr == spi_readback_pkg::SELECT_ADDR)
                    sel_code_reg <= shift_reg[4:0]; // [RULE7] [RULE9]
            end
        end
    end

    assign readback_code_o = sel_code_reg;

    // Fault capture held off during a frame, released by a valid end
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            fault_capture_en_o <= 1'h1;
        else if (cs_fall)
            fault_capture_en_o <= 1'h0;
        else if (cs_rise && frame_valid)
            fault_capture_en_o <= 1'h1; // [RULE6]
    end

    ////////////////////////////////////////////////////////////////////////
    // Return word selection
    logic [8:0]  item;
    logic [15:0] ret_word;
    logic [1:0]  out_sel;
    logic        fault_read;

    assign out_sel    = sel_code_reg[4:3]; // [RULE8]
    assign fault_read = sel_code_reg[2:0] == spi_readback_pkg::CODE_FAULT;

    always_comb
    begin
        item = 9'h000;
        case (sel_code_reg) // [RULE16] [RULE15]
            spi_readback_pkg::CODE_GLOBAL:
                item = global_config_i; // [RULE19]
            spi_readback_pkg::CODE_DIAG0:
                item = {6'h00, diag_word_zero_i}; // [RULE20]
            spi_readback_pkg::CODE_DIAG1:
                item = {4'h0, din_s, watchdog_active_flag_i}; // [RULE21]
            spi_readback_pkg::CODE_IDENT:
                item = IDENT_BITS;
            default:
            begin
                case (sel_code_reg[2:0])
                    spi_readback_pkg::CODE_FAULT:
                        item = {por_flag_reg,
                                fault_latch_i[out_sel*8 +: 8]}; // [RULE18]
                    spi_readback_pkg::CODE_DUTY:
                        item = {1'h0, duty_register_i[out_sel*8 +: 8]};
                    spi_readback_pkg::CODE_CFG_A:
                        item = {3'h0, output_config_a_i[out_sel*6 +: 6]};
                    spi_readback_pkg::CODE_FCFG:
                        item = {2'h0,
                                output_fault_config_i[out_sel*7 +: 7]};
                    spi_readback_pkg::CODE_ILIM:
                        item = {1'h0,
                                current_limit_config_i[out_sel*8 +: 8]};
                    default:
                        item = 9'h000;
                endcase
            end
        endcase
    end

    // Previous watchdog bit, code echo, run flag, selected item
    assign ret_word = {watchdog_toggle_bit_o, sel_code_reg,
                       normal_run_flag_i, item}; // [RULE12] [RULE13] [RULE14]

    // Power-on flag: a new event wins over the clear by a read
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            por_flag_reg <= spi_readback_pkg::POR_RESET;
        else if (power_on_event_i)
            por_flag_reg <= 1'h1;
        else if (cs_fall && fault_read)
            por_flag_reg <= 1'h0; // [RULE18]
    end

    ////////////////////////////////////////////////////////////////////////
    // Shifter: one register serves return word, command and echo
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            shift_reg <= spi_readback_pkg::WORD_RESET; // [RULE17]
        else if (cs_fall)
            shift_reg <= ret_word; // [RULE1] [RULE3] [RULE10]
        else if (sclk_rise)
            shift_reg <= {shift_reg[14:0], si_s}; // [RULE2] [RULE4]
    end

    // Output changes on the falling edge so the master samples it stable
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            so_o      <= 1'h0;
            so_oe_n_o <= 1'h1;
        end
        else if (cs_fall)
        begin
            so_o      <= ret_word[spi_readback_pkg::WD_BIT];
            so_oe_n_o <= 1'h0;
        end
        else if (cs_rise)
            so_oe_n_o <= 1'h1; // [RULE6]
        else if (sclk_fall)
            so_o      <= shift_reg[15]; // [RULE2]
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_load;
        cs_fall |=> shift_reg == $past(ret_word);
    endproperty
    a_load: assert property (p_load) // [RULE1]
        else $error("return word not loaded at select fall");

    property p_first_bit;
        cs_fall |=> so_o == $past(watchdog_toggle_bit_o) && !so_oe_n_o;
    endproperty
    a_first_bit: assert property (p_first_bit) // [RULE12]
        else $error("top bit not driven at select fall");

    property p_shift_in;
        sclk_rise && !cs_fall |=>
            shift_reg == {$past(shift_reg[14:0]), $past(si_s)};
    endproperty
    a_shift_in: assert property (p_shift_in) // [RULE4]
        else $error("received bit not shifted in");

    property p_commit_len;
        write_strobe_o |-> $past(any_bits_reg) && $past(count_reg) == 4'h0;
    endproperty
    a_commit_len: assert property (p_commit_len) // [RULE5]
        else $error("commit after bad frame length");

    property p_release;
        cs_rise |=> so_oe_n_o ##1 so_oe_n_o;
    endproperty
    a_release: assert property (p_release) // [RULE6]
        else $error("output not released after select rise");

    property p_select;
        cs_rise && frame_valid && rx_addr == spi_readback_pkg::SELECT_ADDR
            |=> sel_code_reg == $past(shift_reg[4:0]);
    endproperty
    a_select: assert property (p_select) // [RULE7]
        else $error("readback code not taken");

    property p_invalid;
        cs_rise && !frame_valid |=> $stable(sel_code_reg)
            && $stable(watchdog_toggle_bit_o) && !write_strobe_o;
    endproperty
    a_invalid: assert property (p_invalid) // [RULE11]
        else $error("invalid frame changed state");

    property p_run_flag;
        cs_fall |=> shift_reg[9] == $past(normal_run_flag_i);
    endproperty
    a_run_flag: assert property (p_run_flag) // [RULE14]
        else $error("run flag missing from return word");

    property p_por_clear;
        cs_fall && fault_read && !power_on_event_i |=> !por_flag_reg;
    endproperty
    a_por_clear: assert property (p_por_clear) // [RULE18]
        else $error("power-on flag not cleared by read");

endmodule

// >>> shared/spi_readback_pkg.sv
/*
 * Constants for the serial status readback block: command word layout,
 * readback codes, field widths and reset values.
 * Assumes a 16-bit framed serial link with an active-low select.
 */
package spi_readback_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command and return word layout
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CNT_W       = 4;
    localparam int unsigned WD_BIT      = 15;
    localparam int unsigned ADDR_HI     = 14;
    localparam int unsigned ADDR_LO     = 10;
    localparam int unsigned NORMAL_BIT  = 9;
    localparam int unsigned CODE_W      = 5;
    localparam int unsigned DATA_W      = 9;
    localparam int unsigned OUTS        = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register field widths per output, and the diag word zero width
    localparam int unsigned FAULT_W     = 8;
    localparam int unsigned DUTY_W      = 8;
    localparam int unsigned CFGA_W      = 6;
    localparam int unsigned FCFG_W      = 7;
    localparam int unsigned ILIM_W      = 8;
    localparam int unsigned DIAG0_W     = 3;

    ////////////////////////////////////////////////////////////////////////
    // Command address of the readback select command
    localparam logic [4:0] SELECT_ADDR  = 5'h00;

    // Per-output codes: low three bits, output index in the top two
    localparam logic [2:0] CODE_FAULT   = 3'h0;
    localparam logic [2:0] CODE_DUTY    = 3'h1;
    localparam logic [2:0] CODE_CFG_A   = 3'h2;
    localparam logic [2:0] CODE_FCFG    = 3'h3;
    localparam logic [2:0] CODE_ILIM    = 3'h4;

    // Global codes
    localparam logic [4:0] CODE_GLOBAL  = 5'h05;
    localparam logic [4:0] CODE_DIAG0   = 5'h07;
    localparam logic [4:0] CODE_DIAG1   = 5'h0F;
    localparam logic [4:0] CODE_IDENT   = 5'h17;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [4:0] CODE_RESET   = 5'h00;
    localparam logic       POR_RESET    = 1'h1;
    localparam logic [15:0] WORD_RESET  = 16'h0000;

    // Sampled pins: sclk, cs_n, si, direct inputs 3..0
    localparam int unsigned PIN_W       = 7;
    localparam logic [6:0] PIN_RESET    = 7'h30;

endpackage

// >>> core/pin_sync.sv
/*
 * Two-stage synchroniser for a group of asynchronous pin levels.
 * Assumes each bit is a slow level relative to the sampling clock.
 */
module pin_sync #(
    parameter int unsigned W         = 1,
    parameter logic [W-1:0] RST_VAL  = '0
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    generate
        for (genvar b = 0; b < W; b++)
        begin : g_bit
            always_ff @(posedge core_clk_i)
            begin
                if (rst_i)
                begin
                    meta_reg[b] <= RST_VAL[b];
                    sync_o[b]   <= RST_VAL[b];
                end
                else
                begin
                    meta_reg[b] <= async_i[b];
                    sync_o[b]   <= meta_reg[b];
                end
            end
        end
    endgenerate

endmodule

// >>> verification/spi_master_model.sv
/*
 * Serial master model: runs one frame of nbits_i bits, MSB first, per
 * start_i pulse, and collects what the slave returns.
 * Assumes start_i is a one-cycle pulse and inputs hold until done_o.
 */
module spi_master_model (
    // Control from the bench
    input  wire logic        core_clk_i,
    input  wire logic        start_i,
    input  wire logic        slow_i,
    input  wire logic [5:0]  nbits_i,
    input  wire logic [31:0] word_i,
    // Return pin
    input  wire logic        so_i,
    // Link pins and result
    output logic             sclk_o,
    output logic             cs_n_o,
    output logic             si_o,
    output logic             done_o,
    output logic [31:0]      rx_o
);
    timeunit 1ns;
    timeprecision 1ps;

    realtime half;

    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
        done_o = 1'b0;
        rx_o   = 32'h0;
        forever
        begin
            @(posedge core_clk_i iff start_i);
            half = slow_i ? 250.0 : 62.5;
            rx_o = 32'h0;
            #20 cs_n_o = 1'b0;
            for (int i = int'(nbits_i) - 1; i >= 0; i--)
            begin
                // Host places the command, select code included
                si_o = word_i[i];
                #(half) sclk_o = 1'b1;
                rx_o = {rx_o[30:0], so_i};
                #(half) sclk_o = 1'b0;
            end
            #(half) cs_n_o = 1'b1;
            // Released line must not keep its last level
            si_o = ~si_o;
            @(posedge core_clk_i);
            done_o <= 1'b1;
            @(posedge core_clk_i);
            done_o <= 1'b0;
        end
    end
endmodule

// >>> verification/test_spi_status_readback.sv
/*
 * Self-checking bench: frames go through the master model, a monitor
 * pops expectations as results appear.
 * Assumes the package and the master model are compiled first.
 */
module test_spi_status_readback;
    timeunit 1ns;
    timeprecision 1ps;

    // Arbitrary identity bits; bit 2 set as the family needs
    localparam logic [8:0] ID_VAL = 9'h0A5;

    logic        core_clk, rst, start, slow, normal, por_ev, wd_act;
    logic        sclk, cs_n, si, so, so_oe_n, done, wstb, wdt, cap_en;
    logic [5:0]  nbits;
    logic [31:0] word, flt, duty, ilim, rx, ex_w;
    logic [23:0] cfga;
    logic [27:0] fcfg;
    logic [8:0]  gcfg, wdata;
    logic [4:0]  waddr, rcode, e_code;
    logic [3:0]  din;
    logic [2:0]  dg0;
    logic        e_wd, e_por;
    logic [13:0] ex_c;
    logic [15:0] lfsr = 16'h05F9;
    int          n_fail = 0;
    int          num_checks = 0;
    logic [31:0] q_rx[$];
    logic [13:0] q_cmd[$];

    spi_status_readback #(.IDENT_BITS(ID_VAL)) dut_u (
        .core_clk_i             (core_clk),
        .rst_i                  (rst),
        .sclk_i                 (sclk),
        .cs_n_i                 (cs_n),
        .si_i                   (si),
        .so_o                   (so),
        .so_oe_n_o              (so_oe_n),
        .direct_input_i         (din),
        .normal_run_flag_i      (normal),
        .power_on_event_i       (por_ev),
        .fault_latch_i          (flt),
        .duty_register_i        (duty),
        .output_config_a_i      (cfga),
        .output_fault_config_i  (fcfg),
        .current_limit_config_i (ilim),
        .global_config_i        (gcfg),
        .diag_word_zero_i       (dg0),
        .watchdog_active_flag_i (wd_act),
        .write_strobe_o         (wstb),
        .write_addr_o           (waddr),
        .write_data_o           (wdata),
        .watchdog_toggle_bit_o  (wdt),
        .fault_capture_en_o     (cap_en),
        .readback_code_o        (rcode)
    );

    spi_master_model master_u (
        .core_clk_i (core_clk),
        .start_i    (start),
        .slow_i     (slow),
        .nbits_i    (nbits),
        .word_i     (word),
        .so_i       (so),
        .sclk_o     (sclk),
        .cs_n_o     (cs_n),
        .si_o       (si),
        .done_o     (done),
        .rx_o       (rx)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [31:0] seen, logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, want, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [15:0] sel_w(logic wd, logic [4:0] c);
        return {wd, spi_readback_pkg::SELECT_ADDR, 5'h00, c};
    endfunction

    function automatic logic [8:0] item_f(logic [4:0] c);
        int s;
        s = int'(c[4:3]);
        case (c)
            spi_readback_pkg::CODE_GLOBAL: return gcfg;
            spi_readback_pkg::CODE_DIAG0:  return {6'h00, dg0};
            spi_readback_pkg::CODE_DIAG1:  return {4'h0, din, wd_act};
            spi_readback_pkg::CODE_IDENT:  return ID_VAL;
            default: ;
        endcase
        case (c[2:0])
            spi_readback_pkg::CODE_FAULT: return {e_por, flt[8*s +: 8]};
            spi_readback_pkg::CODE_DUTY:  return {1'b0, duty[8*s +: 8]};
            spi_readback_pkg::CODE_CFG_A: return {3'h0, cfga[6*s +: 6]};
            spi_readback_pkg::CODE_FCFG:  return {2'h0, fcfg[7*s +: 7]};
            spi_readback_pkg::CODE_ILIM:  return {1'b0, ilim[8*s +: 8]};
            default: return 9'h000;
        endcase
    endfunction

    // Next state of the 16-bit feedback shift register, maximal length
    function automatic logic [15:0] lfsr_next(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Random device state from the feedback shift register
    task automatic scramble();
        logic [31:0] r[6];
        foreach (r[i])
        begin
            lfsr = lfsr_next(lfsr);
            r[i] = {lfsr, ~lfsr[7:0], lfsr[15:8]};
        end
        @(posedge core_clk);
        flt <= r[0];
        duty <= r[1];
        ilim <= r[2];
        cfga <= r[3][23:0];
        fcfg <= r[4][27:0];
        {gcfg, dg0, din, wd_act} <= r[5][16:0];
    endtask

    // Queues the expected return and commit, then runs one frame;
    // inputs change mid-frame so a late sample would show
    task automatic frame(input int nb, input logic [31:0] w, input bit sl);
        logic [15:0] ret;
        logic [31:0] ex;
        bit          ok;
        @(posedge core_clk);
        ret = {e_wd, e_code, normal, item_f(e_code)};
        ex = 32'h0;
        // An empty frame is refused just like a short one
        ok = (nb % 16 == 0) && (nb > 0);
        for (int i = 0; i < nb; i++)
            ex = {ex[30:0], (i < 16) ? ret[15-i] : w[nb-1-(i-16)]};
        q_rx.push_back(ex);
        if (e_code[2:0] == spi_readback_pkg::CODE_FAULT)
            e_por = 1'b0;
        if (ok)
        begin
            q_cmd.push_back({w[14:10], w[8:0]});
            e_wd = w[15];
            if (w[14:10] == spi_readback_pkg::SELECT_ADDR)
                e_code = w[4:0];
        end
        start <= 1'b1;
        nbits <= nb[5:0];
        word <= w;
        slow <= sl;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (40) @(posedge core_clk);
        check("oe_in_frame", so_oe_n, 1'b0);
        scramble();
        repeat (3000) if (!done) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        check("oe_idle", so_oe_n, 1'b1);
        check("capture", cap_en, ok);
        check("code", rcode, e_code);
        check("wd_bit", wdt, e_wd);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Monitor: oldest expectation against each result
    always @(posedge core_clk)
    begin
        if (done)
        begin
            ex_w = q_rx.size() ? q_rx.pop_front() : 'x;
            check("rx_high", rx[31:16], ex_w[31:16]);
            check("rx_low", rx[15:0], ex_w[15:0]);
            check("rx_flag", rx[9], ex_w[9]);
            check("rx_item", rx[8:0], ex_w[8:0]);
            check("rx_data", rx[8:0], ex_w[8:0]);
            check("rx_diag", rx[4:0], ex_w[4:0]);
        end
        if (wstb !== 1'h0)
        begin
            ex_c = q_cmd.size() ? q_cmd.pop_front() : 'x;
            check("commit", {waddr, wdata}, ex_c);
        end
    end

    initial
    begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        final_report();
    end

    initial
    begin
        rst = 1'b1;
        {start, slow, nbits, word, normal, por_ev} = '0;
        {flt, duty, ilim, cfga, fcfg, gcfg, dg0, din, wd_act} = '0;
        e_code = spi_readback_pkg::CODE_RESET;
        e_wd = 1'b0;
        e_por = spi_readback_pkg::POR_RESET;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        frame(16, sel_w(1'b1, spi_readback_pkg::CODE_FAULT), 1'b0);
        normal <= 1'b1;
        frame(16, sel_w(1'b0, spi_readback_pkg::CODE_FAULT), 1'b0);
        por_ev <= 1'b1;
        @(posedge core_clk);
        por_ev <= 1'b0;
        e_por = 1'b1;
        frame(16, sel_w(1'b1, spi_readback_pkg::CODE_FAULT), 1'b0);
        $display("test reset_and_power_on done");
        // Every code, including the unused ones that read zero
        for (int c = 0; c < 32; c++)
            frame(16, sel_w(lfsr[0], c[4:0]), 1'b0);
        $display("test code_map done");
        // Commands to other addresses leave the selection alone
        repeat (2) frame(16, {16'h0, lfsr[15:10], 1'b0, lfsr[8:0]} | 32'h0400,
                         1'b0);
        frame(8, 32'h0000_00FF, 1'b0);
        // Select pulsed with no clocks: slow window so the enable is seen
        frame(0, 32'h0000_FFFF, 1'h1);
        frame(16, sel_w(1'b0, 5'h09), 1'b0);
        $display("test persistence_and_bad_length done");
        // Two words: the second half returns the first word sent
        frame(32, {16'hA5C3, sel_w(1'b1, 5'h0F)}, 1'b0);
        frame(16, sel_w(1'b0, 5'h17), 1'b1);
        frame(16, sel_w(1'b1, 5'h07), 1'b0);
        $display("test chaining_and_slow_link done");
        // Reset in mid-run puts the returned fields back to reset state
        rst <= 1'h1;
        repeat (10) @(posedge core_clk);
        rst <= 1'h0;
        e_code = spi_readback_pkg::CODE_RESET;
        e_wd = 1'h0;
        e_por = spi_readback_pkg::POR_RESET;
        repeat (4) @(posedge core_clk);
        check("reset_code", rcode, e_code);
        check("reset_wd", wdt, e_wd);
        frame(16, sel_w(1'h0, spi_readback_pkg::CODE_DIAG1), 1'h0);
        $display("test mid_run_reset done");
        // Every queued result must have shown up at the outputs
        check("rx_left", q_rx.size(), 32'h0);
        check("cmd_left", q_cmd.size(), 32'h0);
        final_report();
    end
endmodule
